/* File: psr_params.svh */
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH
// Clock period in picoseconds (250 MHz)
`define PSR_CLK_PS         4000
// Memory geometry
`define PSR_ADDR_W         15
`define PSR_DATA_W         8
// Timing figures in ns, slowest grade so one build serves all parts
`define PSR_T_RC_NS        190
`define PSR_T_RMW_NS       280
`define PSR_T_CE_NS        120
`define PSR_T_P_NS         60
`define PSR_T_CEA_NS       120
`define PSR_T_WP_NS        85
`define PSR_T_DS_NS        50
`define PSR_T_AH_NS        30
`define PSR_T_FC_NS        190
`define PSR_T_RFD_NS       60
`define PSR_T_FAP_NS       80
`define PSR_T_FAP_MAX_NS   8000
`define PSR_T_FCE_NS       225
`define PSR_T_FAS_NS       8000
`define PSR_T_FRS_NS       225
`define PSR_T_FST_NS       10
`define PSR_T_FHT_NS       65
`define PSR_T_PAUSE_NS     1000000
`define PSR_T_REF_NS       4000000
`define PSR_ROWS           256
// Least times round up to whole cycles
`define PSR_CYC_MIN(ns)    (((ns) * 1000 + `PSR_CLK_PS - 1) / `PSR_CLK_PS)
// Longest times round down
`define PSR_CYC_MAX(ns)    (((ns) * 1000) / `PSR_CLK_PS)
`endif

/* File: psr_pkg.sv */
`default_nettype none
package psr_pkg;
	// Host request to the controller
	typedef struct packed {
		logic        write;
		logic        rmw;
		logic        test;
		logic [14:0] addr;
		logic [7:0]  wdata;
	} psr_req_type;

	// Pins driven toward the memory
	typedef struct packed {
		logic        ce_n;
		logic        rw;
		logic        output_enable_refresh_n;
		logic [14:0] addr_in;
		logic [7:0]  data_out;
		logic        data_oe_n;
	} psr_pins_type;

	typedef enum logic [3:0] {
		PSR_ST_PAUSE  = 4'b0000,
		PSR_ST_IDLE   = 4'b0001,
		PSR_ST_ACTIVE = 4'b0011,
		PSR_ST_WRITE  = 4'b0010,
		PSR_ST_PRECH  = 4'b0110,
		PSR_ST_RFSH   = 4'b0111,
		PSR_ST_RECOV  = 4'b0101,
		PSR_ST_SELF   = 4'b0100,
		PSR_ST_TSTSET = 4'b1100
	} psr_state_type;
endpackage
`default_nettype wire

/* File: psr_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// Loadable down counter; done is high while the count is zero
module psr_timer #(
	parameter int WIDTH = 20
) (
	input  wire logic             clk,   // System clock
	input  wire logic             rst_n, // Synchronous reset
	input  wire logic             load,  // Load a new count
	input  wire logic [WIDTH-1:0] value, // Count to load
	output logic                  done   // Count reached zero
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;

	initial begin
		if (WIDTH < 2)
			$error("psr_timer width too small");
	end

	// Next count
	always_comb begin
		cnt_next = cnt_reg;
		if (load)
			cnt_next = value;
		else if (cnt_reg != '0)
			cnt_next = cnt_reg - WIDTH'(1);
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign done = (cnt_reg == '0);
endmodule
`default_nettype wire

/* File: psr_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "psr_params.svh"
// Summary of operation
// [R1] 32768 bytes: 15-bit address, 8-bit data
// [R2] Address stable before and after CE falls
// [R3] Write data held until strobe rises
// [R4] Shared pin: output enable or refresh
// [R5] Auto refresh pulse between 80 and 8000 ns
// [R6] Device counts refresh rows; no address given
// [R7] Pin held 8000 ns enters self refresh
// [R8] Wait after auto refresh before CE
// [R9] Wait after self refresh before CE
// [R10] Space auto refreshes by cycle time
// [R11] CE precharge before refresh pulse starts
// [R12] 1 ms pause with pins high
// [R13] Access cycles spaced by cycle time
// [R14] Read-modify-write takes its minimum time
// [R15] Device floats data after write strobe
// [R16] Device may drive again after strobe
// [R17] Write strobe leads CE deassert enough
// [R18] Counter test uses refresh row, column zero
// [R19] Counter test pin setup and hold
// [R20] Counter test sequence run by software
// [R21] Schedule refresh, arbitrate against accesses
module psr_ctrl #(
	parameter int PAUSE_CYC = `PSR_CYC_MIN(`PSR_T_PAUSE_NS),           // Power-up pause
	parameter int REF_CYC   = `PSR_CYC_MAX(`PSR_T_REF_NS) / `PSR_ROWS, // Refresh interval
	parameter int SELF_CYC  = `PSR_CYC_MIN(`PSR_T_FAS_NS)              // Self refresh entry
) (
	input  wire logic                clk,        // System clock
	input  wire logic                rst_n,      // Synchronous reset
	input  wire logic                req_valid,  // Access request
	output logic                     req_ready,  // Request taken
	input  wire psr_pkg::psr_req_type req,       // Request contents
	input  wire logic                self_req,   // Hold memory in self refresh
	output logic                     rsp_valid,  // Read data valid pulse
	output logic [7:0]               rsp_data,   // Read data
	output logic                     in_self,    // Self refresh active
	output psr_pkg::psr_pins_type    pins,       // Pins to memory
	input  wire logic [7:0]          data_io_in  // Data pins from memory
);
	localparam int TW = 20;
	localparam int C_CEA  = `PSR_CYC_MIN(`PSR_T_CEA_NS);
	localparam int C_CE   = `PSR_CYC_MIN(`PSR_T_CE_NS);
	localparam int C_WP   = `PSR_CYC_MIN(`PSR_T_WP_NS);
	localparam int C_P    = `PSR_CYC_MIN(`PSR_T_P_NS);
	localparam int C_RC   = `PSR_CYC_MIN(`PSR_T_RC_NS);
	localparam int C_RMW  = `PSR_CYC_MIN(`PSR_T_RMW_NS);
	localparam int C_FAP  = `PSR_CYC_MIN(`PSR_T_FAP_NS);
	localparam int C_FC   = `PSR_CYC_MIN(`PSR_T_FC_NS);
	localparam int C_FCE  = `PSR_CYC_MIN(`PSR_T_FCE_NS);
	localparam int C_FST  = `PSR_CYC_MIN(`PSR_T_FST_NS);
	localparam int C_FHT  = `PSR_CYC_MIN(`PSR_T_FHT_NS);
	localparam int C_RFD  = `PSR_CYC_MIN(`PSR_T_RFD_NS);

	initial begin
		if (PAUSE_CYC < 1 || REF_CYC < C_FC + C_FCE || SELF_CYC < C_FAP)
			$error("psr_ctrl timing parameters out of range");
		if (PAUSE_CYC >= (1 << TW) || SELF_CYC >= (1 << TW))
			$error("psr_ctrl counts exceed timer width");
		if (C_FAP >= `PSR_CYC_MAX(`PSR_T_FAP_MAX_NS))
			$error("psr_ctrl auto refresh pulse too long");
	end

	psr_pkg::psr_state_type state_reg, state_next;
	psr_pkg::psr_req_type   req_reg, req_next;
	psr_pkg::psr_pins_type  pins_reg, pins_next;
	logic [TW-1:0] ph_reg, ph_next;       // Phase counter within a cycle
	logic [TW-1:0] ref_reg, ref_next;     // Refresh interval counter
	logic          ref_due_reg, ref_due_next;
	logic [7:0]    rsp_data_reg, rsp_data_next;
	logic          rsp_valid_reg, rsp_valid_next;
	logic [7:0]    din_s1_reg, din_s2_reg;
	logic          tm_load;
	logic [TW-1:0] tm_value;
	logic          tm_done;

	// Gap timer enforces spacing after each cycle
	psr_timer #(.WIDTH(TW)) u_gap (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (tm_load),
		.value (tm_value),
		.done  (tm_done)
	);

	function automatic logic [TW-1:0] cyc(input int n);
		return TW'(n);
	endfunction

	// Read data pins pass two flops since the memory is unclocked
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			din_s1_reg <= 8'h00;
			din_s2_reg <= 8'h00;
		end else begin
			din_s1_reg <= data_io_in;
			din_s2_reg <= din_s1_reg;
		end
	end

	// Main sequencer
	always_comb begin
		state_next     = state_reg;
		req_next       = req_reg;
		pins_next      = pins_reg;
		ph_next        = ph_reg + cyc(1);
		ref_next       = ref_reg;
		ref_due_next   = ref_due_reg;
		rsp_data_next  = rsp_data_reg;
		rsp_valid_next = 1'b0;
		tm_load        = 1'b0;
		tm_value       = '0;
		req_ready      = 1'b0;
		case (state_reg)
			psr_pkg::PSR_ST_PAUSE: begin
				pins_next.ce_n = 1'b1; // R12
				pins_next.output_enable_refresh_n = 1'b1; // R12
				if (ph_reg >= cyc(PAUSE_CYC - 1))
					state_next = psr_pkg::PSR_ST_IDLE;
			end
			psr_pkg::PSR_ST_IDLE: begin
				ph_next = '0;
				if (tm_done) begin
					if (ref_due_reg || self_req) begin
						// Refresh beats accesses; precharge already met by gap
						pins_next.output_enable_refresh_n = 1'b0; // R4 R11
						state_next = self_req ? psr_pkg::PSR_ST_SELF : psr_pkg::PSR_ST_RFSH; // R21
						if (!self_req)
							ref_due_next = 1'b0;
					end else if (req_valid) begin
						req_ready = 1'b1;
						req_next  = req;
						pins_next.addr_in = req.addr; // R1 R2
						pins_next.rw      = 1'b1;
						pins_next.data_out = req.wdata;
						if (req.test) begin
							// Pin leads CE by the counter test setup
							pins_next.output_enable_refresh_n = 1'b0; // R18 R19 R20
							state_next = psr_pkg::PSR_ST_TSTSET;
						end else begin
							state_next = psr_pkg::PSR_ST_ACTIVE;
						end
					end
				end
			end
			psr_pkg::PSR_ST_TSTSET: begin
				if (ph_reg >= cyc(C_FST - 1)) begin
					pins_next.ce_n = 1'b0; // R19
					ph_next = '0;
					state_next = psr_pkg::PSR_ST_ACTIVE;
				end
			end
			psr_pkg::PSR_ST_ACTIVE: begin
				// Address held past CE fall; pins registered so it is stable
				pins_next.ce_n = 1'b0; // R2
				if (req_reg.test && ph_reg >= cyc(C_FHT))
					pins_next.output_enable_refresh_n = 1'b1; // R19
				// Enable falls a cycle after CE, or the memory would see a counter test
				else if (!req_reg.test && (!req_reg.write || req_reg.rmw) && ph_reg >= cyc(1))
					pins_next.output_enable_refresh_n = 1'b0; // R4
				if ((req_reg.write && !req_reg.rmw) ||
				    ph_reg >= cyc(C_CEA + 3)) begin
					if (!req_reg.write || req_reg.rmw) begin
						rsp_data_next  = din_s2_reg;
						rsp_valid_next = !req_reg.write || req_reg.rmw;
					end
					if (req_reg.write) begin
						// Release bus control as the strobe falls, in the same cycle; device floats data
						if (!req_reg.test)
							pins_next.output_enable_refresh_n = 1'b1; // R15
						pins_next.rw        = 1'b0; // R17
						pins_next.data_oe_n = 1'b0; // R3
						ph_next    = '0;
						state_next = psr_pkg::PSR_ST_WRITE;
					end else if (ph_reg >= cyc(C_CE - 1)) begin
						// Enable rises before CE so it is never taken as a refresh
						pins_next.output_enable_refresh_n = 1'b1; // R4
						state_next = psr_pkg::PSR_ST_PRECH;
					end
				end
			end
			psr_pkg::PSR_ST_WRITE: begin
				// Strobe held past pulse width and data setup
				if (req_reg.test && ph_reg >= cyc(C_FHT))
					pins_next.output_enable_refresh_n = 1'b1; // R19
				if (ph_reg >= cyc(C_WP - 1) && ph_reg >= cyc(C_CE - 1)) begin
					pins_next.rw = 1'b1; // R3 R16
					state_next   = psr_pkg::PSR_ST_PRECH;
				end
			end
			psr_pkg::PSR_ST_PRECH: begin
				// Data released one cycle after strobe rises for hold
				pins_next.ce_n      = 1'b1;
				pins_next.data_oe_n = 1'b1;
				pins_next.output_enable_refresh_n = 1'b1;
				tm_load    = 1'b1;
				tm_value   = req_reg.rmw ? cyc(C_RMW - C_CE) : cyc(C_RC - C_CE); // R13 R14
				if (tm_value < cyc(C_P))
					tm_value = cyc(C_RFD); // R11
				state_next = psr_pkg::PSR_ST_IDLE;
			end
			psr_pkg::PSR_ST_RFSH: begin
				// Auto refresh; row comes from the device counter
				if (ph_reg >= cyc(C_FAP - 1)) begin
					pins_next.output_enable_refresh_n = 1'b1; // R5 R6
					ph_next    = '0;
					state_next = psr_pkg::PSR_ST_RECOV;
				end
			end
			psr_pkg::PSR_ST_SELF: begin
				// Pulse must reach self refresh length before release
				if (!self_req && ph_reg >= cyc(SELF_CYC - 1)) begin
					pins_next.output_enable_refresh_n = 1'b1; // R7
					ph_next    = '0;
					state_next = psr_pkg::PSR_ST_RECOV;
				end else if (ph_reg >= cyc(SELF_CYC)) begin
					ph_next = ph_reg;
				end
			end
			psr_pkg::PSR_ST_RECOV: begin
				tm_load    = 1'b1;
				tm_value   = cyc(C_FCE > C_FC ? C_FCE : C_FC); // R8 R9 R10
				state_next = psr_pkg::PSR_ST_IDLE;
			end
			default: begin
				state_next = psr_pkg::PSR_ST_PAUSE;
			end
		endcase
		// Refresh interval tick after the states, so a tick beats a same-cycle clear
		if (ref_reg >= cyc(REF_CYC - 1)) begin
			ref_next     = '0;
			ref_due_next = 1'b1; // R21
		end else begin
			ref_next = ref_reg + cyc(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg     <= psr_pkg::PSR_ST_PAUSE;
			req_reg       <= '0;
			pins_reg      <= '{ce_n: 1'b1, rw: 1'b1, output_enable_refresh_n: 1'b1,
			                   addr_in: 15'h0000, data_out: 8'h00, data_oe_n: 1'b1};
			ph_reg        <= '0;
			ref_reg       <= '0;
			ref_due_reg   <= 1'b0;
			rsp_data_reg  <= 8'h00;
			rsp_valid_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			req_reg       <= req_next;
			pins_reg      <= pins_next;
			ph_reg        <= ph_next;
			ref_reg       <= ref_next;
			ref_due_reg   <= ref_due_next;
			rsp_data_reg  <= rsp_data_next;
			rsp_valid_reg <= rsp_valid_next;
		end
	end

	assign pins      = pins_reg;
	assign rsp_data  = rsp_data_reg;
	assign rsp_valid = rsp_valid_reg;
	assign in_self   = (state_reg == psr_pkg::PSR_ST_SELF);
endmodule
`default_nettype wire

/* File: psr_ctrl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// Pin timing watcher for the memory controller
module psr_ctrl_sva #(
	parameter int PAUSE_CYC = 250000, // Power-up pause
	parameter int REF_CYC   = 3906,   // Refresh interval
	parameter int SELF_CYC  = 2000    // Self refresh entry
) (
	input wire logic                  clk,        // System clock
	input wire logic                  rst_n,      // Synchronous reset
	input wire logic                  req_valid,  // Access request
	input wire logic                  req_ready,  // Request taken
	input wire psr_pkg::psr_req_type  req,        // Request contents
	input wire logic                  self_req,   // Self refresh hold
	input wire logic                  rsp_valid,  // Read data valid
	input wire logic [7:0]            rsp_data,   // Read data
	input wire logic                  in_self,    // Self refresh active
	input wire psr_pkg::psr_pins_type pins,       // Pins to memory
	input wire logic [7:0]            data_io_in  // Data from memory
);
	logic        ce_q;
	logic        oe_q;
	logic        rw_q;
	logic [31:0] up_cnt;
	logic [31:0] fall_cnt;
	logic [31:0] hi_cnt;
	logic [31:0] lo_cnt;
	logic [31:0] rf_cnt;
	logic [31:0] wl_cnt;
	wire         ce_fall = ce_q && !pins.ce_n;
	wire         rf_end  = !oe_q && pins.output_enable_refresh_n && pins.ce_n && ce_q;
	wire         rw_rise = !rw_q && pins.rw;
	function automatic logic [31:0] inc(logic [31:0] v);
		return v + 32'(v != '1);
	endfunction
	// Edge history and saturating counters; saturation avoids wrap in long idle spells
	always_ff @(posedge clk) begin
		ce_q     <= rst_n ? pins.ce_n : 1'b1;
		oe_q     <= rst_n ? pins.output_enable_refresh_n : 1'b1;
		rw_q     <= rst_n ? pins.rw : 1'b1;
		up_cnt   <= rst_n ? inc(up_cnt) : '0;
		fall_cnt <= !rst_n ? '1 : ce_fall ? 32'h0000_0001 : inc(fall_cnt);
		hi_cnt   <= !rst_n ? '1 : pins.ce_n ? inc(hi_cnt) : '0;
		lo_cnt   <= pins.output_enable_refresh_n ? '0 : inc(lo_cnt);
		rf_cnt   <= !rst_n ? '1 : rf_end ? '0 : inc(rf_cnt);
		wl_cnt   <= (!rst_n || pins.rw) ? '0 : inc(wl_cnt);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_read_start;
		ce_fall && pins.rw ##1 !pins.ce_n && pins.rw && !pins.output_enable_refresh_n;
	endsequence
	sequence s_rfsh_end;
		rf_end;
	endsequence
	a_pause_hold: assert property (up_cnt < PAUSE_CYC |-> pins.ce_n && pins.output_enable_refresh_n && !req_ready)
		else $error("access during power-up pause");
	a_cycle_space: assert property (ce_fall |-> fall_cnt >= 48)
		else $error("access cycles too close");
	a_pre_charge: assert property (oe_q && !pins.output_enable_refresh_n && pins.ce_n |-> hi_cnt >= 15)
		else $error("refresh pulse too soon after enable");
	a_pulse_width: assert property (s_rfsh_end |-> lo_cnt >= 20 && (lo_cnt <= 2000 || lo_cnt >= SELF_CYC))
		else $error("refresh pulse width out of range");
	a_rfsh_recover: assert property (ce_fall |-> rf_cnt >= 57)
		else $error("enable too soon after refresh");
	a_write_pulse: assert property (rw_rise |-> wl_cnt >= 22)
		else $error("write strobe too short");
	a_addr_hold: assert property (!pins.ce_n && $past(!pins.ce_n) |-> $stable(pins.addr_in))
		else $error("address moved while enabled");
	a_data_hold: assert property (!pins.rw && $past(!pins.rw) |-> $stable(pins.data_out))
		else $error("write data moved under strobe");
	a_drive_sel: assert property (!pins.data_oe_n |-> !pins.ce_n)
		else $error("data driven while deselected");
	a_self_hold: assert property (in_self |-> pins.ce_n && !pins.output_enable_refresh_n)
		else $error("self refresh pins wrong");
	a_read_data: assert property (s_read_start |-> ##[25:45] rsp_valid)
		else $error("read data late");
endmodule
bind psr_ctrl psr_ctrl_sva #(.PAUSE_CYC(PAUSE_CYC), .REF_CYC(REF_CYC), .SELF_CYC(SELF_CYC)) i_sva (
	.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req), .self_req(self_req),
	.rsp_valid(rsp_valid), .rsp_data(rsp_data), .in_self(in_self), .pins(pins), .data_io_in(data_io_in));
`default_nettype wire

/* File: psr_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Behavioural pseudo-static memory at the far side of the pins
module psr_mem_model #(
	parameter int ACC_NS = 110 // Access time; a value on a clock edge makes a race
) (
	input  wire psr_pkg::psr_pins_type pins,   // Controller pins
	output logic [7:0]                 data_io // Data toward the controller
);
	logic [7:0]  mem [32768];
	logic [14:0] addr_lat;
	logic [7:0]  row_cnt;
	logic [7:0]  last;
	logic        test_mode;
	logic        wr_pend;
	int          test_count;
	wire         drive = !pins.ce_n && pins.rw && (!pins.output_enable_refresh_n || test_mode);
	// Cells start cleared so a first read has a known value
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		row_cnt = 8'h00;
		last = 8'h00;
		wr_pend = 1'b0;
		test_count = 0;
	end
	// Address caught as enable falls; a pin already low selects the counter row
	always @(negedge pins.ce_n) begin
		test_mode = !pins.output_enable_refresh_n;
		addr_lat = test_mode ? {row_cnt, 7'h00} : pins.addr_in;
		test_count += test_mode;
	end
	// Write data taken at the earlier of strobe or enable rising
	always @(negedge pins.rw) wr_pend = !pins.ce_n;
	always @(posedge pins.rw or posedge pins.ce_n) begin
		if (wr_pend) mem[addr_lat] = pins.data_out;
		wr_pend = 1'b0;
	end
	// Each refresh pulse with enable high advances the row counter
	always @(posedge pins.output_enable_refresh_n) if (pins.ce_n) row_cnt++;
	// Floating bus shows the inverse of the last byte, never a held value
	always @(negedge drive) last = mem[addr_lat];
	assign #(ACC_NS) data_io = drive ? mem[addr_lat] : ~last;
endmodule
`default_nettype wire

/* File: psr_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the memory controller
module psr_ctrl_tb;
	logic                  clk;
	logic                  rst_n;
	logic                  req_valid;
	logic                  req_ready;
	psr_pkg::psr_req_type  req;
	logic                  self_req;
	logic                  rsp_valid;
	logic [7:0]            rsp_data;
	logic                  in_self;
	psr_pkg::psr_pins_type pins;
	logic [7:0]            data_io;
	int                    errors;
	int                    comparisons;
	int                    cycles;
	psr_pkg::psr_req_type  row_req [6];
	logic [7:0]            row_exp [6];
	psr_ctrl #(.PAUSE_CYC(20), .REF_CYC(200), .SELF_CYC(30)) i_dut (.clk(clk), .rst_n(rst_n),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .self_req(self_req), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .in_self(in_self), .pins(pins), .data_io_in(data_io));
	psr_mem_model i_mem (.pins(pins), .data_io(data_io));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic complete_run();
		$display("Comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Hang guard: a whole run needs well under two thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Hold the request until taken, then wait for read data if any
	task automatic access(psr_pkg::psr_req_type r, logic [7:0] exp);
		int n;
		req <= r;
		req_valid <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 2000);
		req_valid <= 1'b0;
		check("req_ready", 8'(req_ready), 8'h01);
		if (!r.write || r.rmw) begin
			n = 0;
			do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 200);
			check("rsp_data", rsp_data, exp);
		end else begin
			@(posedge clk);
		end
	endtask
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		self_req = 1'b0;
		errors = 0;
		comparisons = 0;
		cycles = 0;
		row_req = '{'{1, 0, 0, 15'h0000, 8'ha5}, '{1, 0, 0, 15'h7fff, 8'h3c}, '{0, 0, 0, 15'h0000, 8'h00},
			'{0, 0, 0, 15'h7fff, 8'h00}, '{1, 1, 0, 15'h1234, 8'h0f}, '{0, 0, 0, 15'h1234, 8'h00}};
		row_exp = '{8'h00, 8'h00, 8'ha5, 8'h3c, 8'h00, 8'h0f};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		foreach (row_req[i]) access(row_req[i], row_exp[i]);
		// Self refresh: pins held, then data must survive
		self_req <= 1'b1;
		repeat (150) @(posedge clk);
		check("in_self", 8'(in_self), 8'h01);
		check("self_pins", 8'({pins.ce_n, pins.output_enable_refresh_n}), 8'h02);
		self_req <= 1'b0;
		access(row_req[3], 8'h3c);
		// Counter test write lands on the counter row
		access('{1, 0, 1, 15'h0000, 8'h5a}, 8'h00);
		repeat (60) @(posedge clk);
		check("test_cycles", 8'(i_mem.test_count), 8'h01);
		check("test_cell", i_mem.mem[i_mem.addr_lat], 8'h5a);
		check("refresh_rows", 8'(i_mem.row_cnt != 8'h00), 8'h01);
		// Reset in mid-run returns the pins to idle
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		check("reset_pins", 8'({pins.ce_n, pins.output_enable_refresh_n, pins.data_oe_n, req_ready}), 8'h0e);
		rst_n <= 1'b1;
		access(row_req[2], 8'ha5);
		complete_run();
	end
endmodule
`default_nettype wire
